// file: shared/dcm_regs.vh
// Register map, field layout and reset values of the timeslot monitor
`ifndef DCM_REGS_VH
`define DCM_REGS_VH

// Control port width
`define DCM_ADDR_W          8
`define DCM_DATA_W          8

// Register offsets
`define DCM_ADDR_FAS_UPPER  8'h02
`define DCM_ADDR_FAS_LOWER  8'h04
`define DCM_ADDR_TX_SELECT  8'hA8
`define DCM_ADDR_TX_BYTE    8'hA9
`define DCM_ADDR_RX_SELECT  8'hAA
`define DCM_ADDR_RX_BYTE    8'hAB

// Select register fields
`define DCM_SEL_MSB         4
`define DCM_SEL_LSB         0
`define DCM_SEL_W           5
`define DCM_REMOTE_LOOP_BIT 7
`define DCM_LOCAL_LOOP_BIT  6
`define DCM_ALARM_GEN_BIT   5
`define DCM_LINE_RST_BIT    7

// Reset values
`define DCM_TX_SELECT_RST   8'h00
`define DCM_RX_SELECT_RST   8'h00
`define DCM_BYTE_RST        8'h00
`define DCM_READ_IDLE       8'h00

// Frame error counter split
`define DCM_FAS_W           12
`define DCM_FAS_UP_MSB      11
`define DCM_FAS_UP_LSB      6
`define DCM_FAS_LO_MSB      5
`define DCM_FAS_LO_LSB      0
`define DCM_BLK_W           10
`define DCM_BLK_TOP_MSB     9
`define DCM_BLK_TOP_LSB     8

// Frame layout: 32 slots of 8 bits
`define DCM_SLOT_BITS_W     3
`define DCM_FRAME_POS_W     8
`define DCM_LAST_BIT        3'h7
`define DCM_FIRST_POS       8'h00
`define DCM_POS_STEP        8'h01

`endif

// file: logic/dcm_slot_capture.v
// One-direction timeslot capture: collects the eight bits of one selected slot per frame
`timescale 1ns/10ps
`default_nettype none
`include "dcm_regs.vh"

module dcm_slot_capture #(
    parameter SEL_W = `DCM_SEL_W
) (
    input  wire             sys_clk,
    input  wire             rst,
    input  wire             bit_en,
    input  wire             frame_sync,
    input  wire             data_bit,
    input  wire [SEL_W-1:0] slot_sel,
    output reg  [7:0]       byte_reg,
    output reg              update_reg
);

    reg  [`DCM_FRAME_POS_W-1:0] pos_reg;
    reg  [SEL_W-1:0]            sel_hold_reg;
    reg  [6:0]                  shift_reg;
    wire [`DCM_FRAME_POS_W-1:0] cur_pos;
    wire [SEL_W-1:0]            cur_sel;
    wire                        in_slot;
    wire                        last_bit;

    // Frame sync marks bit 0 of slot 0
    assign cur_pos  = frame_sync ? `DCM_FIRST_POS : pos_reg;
    // Select is sampled at frame start so one byte never mixes two slots
    assign cur_sel  = frame_sync ? slot_sel : sel_hold_reg;
    assign in_slot  = (cur_pos[`DCM_FRAME_POS_W-1:`DCM_SLOT_BITS_W] == cur_sel);
    assign last_bit = (cur_pos[`DCM_SLOT_BITS_W-1:0] == `DCM_LAST_BIT);

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pos_reg      <= `DCM_FIRST_POS;
            sel_hold_reg <= {SEL_W{1'b0}};
            shift_reg    <= 7'h00;
            byte_reg     <= `DCM_BYTE_RST;
            update_reg   <= 1'b0;
        end
        else
        begin
            update_reg <= 1'b0;
            if (bit_en)
            begin
                pos_reg      <= cur_pos + `DCM_POS_STEP;
                sel_hold_reg <= cur_sel;
                if (in_slot)
                begin
                    shift_reg <= {shift_reg[5:0], data_bit};
                    // First bit lands in bit 7, last in bit 0
                    if (last_bit)
                    begin
                        byte_reg   <= {shift_reg, data_bit};
                        update_reg <= 1'b1;
                    end
                end
            end
        end
    end

endmodule // dcm_slot_capture

`default_nettype wire

// file: logic/dcm_channel_monitor.v
// Timeslot monitor top: control registers, two slot captures, frame count split
//
// Functional notes
// - Frame error count is 12 bits: MSB upper bit 7, LSB lower bit 2.
// - Upper count register low two bits carry checksum error count top bits.
// - Lower count register low two bits carry far-end block error top bits.
// - One transmit and one receive slot monitored at once, independently.
// - Transmit slot chosen by five-bit field in low bits of transmit select.
// - Receive slot chosen by separate five-bit field in receive select register.
// - Selected slot data appears in the matching monitor byte register.
// - Transmit select at A8: bit 4 field MSB, bit 0 field LSB.
// - Transmit byte at A9: first sent bit in bit 7, last in 0.
// - Transmit select bits 7,6,5: remote loop, local loop, alarm generation enable.
// - Receive byte at AB: first received bit in bit 7, last in 0.
`timescale 1ns/10ps
`default_nettype none
`include "dcm_regs.vh"

module dcm_channel_monitor #(
    parameter SEL_W = `DCM_SEL_W
) (
    input  wire                   sys_clk,
    input  wire                   rst,
    // Parallel control port
    input  wire [`DCM_ADDR_W-1:0] cpu_addr,
    input  wire [`DCM_DATA_W-1:0] cpu_wr_data,
    input  wire                   cpu_wr_en,
    input  wire                   cpu_rd_en,
    output reg  [`DCM_DATA_W-1:0] cpu_rd_data_reg,
    output reg                    cpu_rd_valid_reg,
    // Transmit stream
    input  wire                   tx_bit_en,
    input  wire                   tx_frame_sync,
    input  wire                   tx_data_bit,
    // Receive stream
    input  wire                   rx_bit_en,
    input  wire                   rx_frame_sync,
    input  wire                   rx_data_bit,
    // Error counter values from the counting logic
    input  wire [`DCM_FAS_W-1:0]  frame_err_count,
    input  wire [`DCM_BLK_W-1:0]  crc_err_count,
    input  wire [`DCM_BLK_W-1:0]  far_end_err_count,
    // Control bits handed to logic outside this block
    output reg                    remote_loop_ctl,
    output reg                    local_loop_ctl,
    output reg                    line_alarm_gen_en,
    output reg                    line_if_reset,
    // Frame update strobes
    output reg                    tx_byte_update,
    output reg                    rx_byte_update
);

    reg  [`DCM_DATA_W-1:0] tx_monitor_select_reg;
    reg  [`DCM_DATA_W-1:0] rx_monitor_select_reg;
    reg  [`DCM_DATA_W-1:0] rd_data_next;
    wire [SEL_W-1:0]       tx_chan_sel;
    wire [SEL_W-1:0]       rx_chan_sel;
    wire [7:0]             tx_monitor_byte;
    wire [7:0]             rx_monitor_byte;
    wire                   tx_update;
    wire                   rx_update;
    wire [`DCM_DATA_W-1:0] fas_count_upper;
    wire [`DCM_DATA_W-1:0] fas_count_lower;
    wire [`DCM_DATA_W-1:0] rx_select_view;
    wire [5:0]             frame_err_high;
    wire [5:0]             frame_err_low;
    wire [1:0]             crc_err_top;
    wire [1:0]             far_end_err_top;
    wire                   wr_tx_select;
    wire                   wr_rx_select;

    // Field MSB at bit 4, LSB at bit 0
    assign tx_chan_sel = tx_monitor_select_reg[`DCM_SEL_MSB:`DCM_SEL_LSB];
    assign rx_chan_sel = rx_monitor_select_reg[`DCM_SEL_MSB:`DCM_SEL_LSB];

    // Frame error count straddles both registers
    assign frame_err_high  = frame_err_count[`DCM_FAS_UP_MSB:`DCM_FAS_UP_LSB];
    assign frame_err_low   = frame_err_count[`DCM_FAS_LO_MSB:`DCM_FAS_LO_LSB];
    // Top two bits of the checksum and far-end counters fill the low bits
    assign crc_err_top     = crc_err_count[`DCM_BLK_TOP_MSB:`DCM_BLK_TOP_LSB];
    assign far_end_err_top = far_end_err_count[`DCM_BLK_TOP_MSB:`DCM_BLK_TOP_LSB];
    assign fas_count_upper = {frame_err_high, crc_err_top};
    assign fas_count_lower = {frame_err_low, far_end_err_top};

    // Unassigned receive select bits 6,5 read as zero
    assign rx_select_view = {rx_monitor_select_reg[`DCM_LINE_RST_BIT], 2'b00,
                             rx_monitor_select_reg[`DCM_SEL_MSB:`DCM_SEL_LSB]};

    // Independent capture per direction
    dcm_slot_capture #(
        .SEL_W      (SEL_W)
    ) u_tx_capture (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .bit_en     (tx_bit_en),
        .frame_sync (tx_frame_sync),
        .data_bit   (tx_data_bit),
        .slot_sel   (tx_chan_sel),
        .byte_reg   (tx_monitor_byte),
        .update_reg (tx_update)
    );

    dcm_slot_capture #(
        .SEL_W      (SEL_W)
    ) u_rx_capture (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .bit_en     (rx_bit_en),
        .frame_sync (rx_frame_sync),
        .data_bit   (rx_data_bit),
        .slot_sel   (rx_chan_sel),
        .byte_reg   (rx_monitor_byte),
        .update_reg (rx_update)
    );

    // Writes to read-only or unmapped addresses are dropped
    assign wr_tx_select = cpu_wr_en && (cpu_addr == `DCM_ADDR_TX_SELECT);
    assign wr_rx_select = cpu_wr_en && (cpu_addr == `DCM_ADDR_RX_SELECT);

    // Transmit select, all eight bits kept and read back
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_monitor_select_reg <= `DCM_TX_SELECT_RST;
        end
        else if (wr_tx_select)
        begin
            tx_monitor_select_reg <= cpu_wr_data;
        end
    end

    // Receive select, unassigned bits masked on read
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_monitor_select_reg <= `DCM_RX_SELECT_RST;
        end
        else if (wr_rx_select)
        begin
            rx_monitor_select_reg <= cpu_wr_data;
        end
    end

    // Read decode
    always @*
    begin
        case (cpu_addr)
            `DCM_ADDR_FAS_UPPER: rd_data_next = fas_count_upper;
            `DCM_ADDR_FAS_LOWER: rd_data_next = fas_count_lower;
            `DCM_ADDR_TX_SELECT: rd_data_next = tx_monitor_select_reg;
            `DCM_ADDR_TX_BYTE:   rd_data_next = tx_monitor_byte;
            `DCM_ADDR_RX_SELECT: rd_data_next = rx_select_view;
            `DCM_ADDR_RX_BYTE:   rd_data_next = rx_monitor_byte;
            default:             rd_data_next = `DCM_READ_IDLE;
        endcase
    end

    // Registered read port, data held until the next read
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_rd_data_reg  <= `DCM_READ_IDLE;
            cpu_rd_valid_reg <= 1'b0;
        end
        else
        begin
            cpu_rd_valid_reg <= cpu_rd_en;
            if (cpu_rd_en)
            begin
                cpu_rd_data_reg <= rd_data_next;
            end
        end
    end

    // Loopback and alarm controls for logic outside this block
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            remote_loop_ctl   <= 1'b0;
            local_loop_ctl    <= 1'b0;
            line_alarm_gen_en <= 1'b0;
        end
        else
        begin
            remote_loop_ctl   <= tx_monitor_select_reg[`DCM_REMOTE_LOOP_BIT];
            local_loop_ctl    <= tx_monitor_select_reg[`DCM_LOCAL_LOOP_BIT];
            line_alarm_gen_en <= tx_monitor_select_reg[`DCM_ALARM_GEN_BIT];
        end
    end

    // Line interface reset from the receive select register
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            line_if_reset <= 1'b0;
        end
        else
        begin
            line_if_reset <= rx_monitor_select_reg[`DCM_LINE_RST_BIT];
        end
    end

    // Frame update strobes, one clock behind the capture
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_byte_update <= 1'b0;
            rx_byte_update <= 1'b0;
        end
        else
        begin
            tx_byte_update <= tx_update;
            rx_byte_update <= rx_update;
        end
    end

endmodule // dcm_channel_monitor

`default_nettype wire

// file: tb/dcm_channel_monitor_properties.sv
// Port-level checks for the timeslot monitor top
`timescale 1ns/10ps
`default_nettype none
module dcm_mon_props (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  cpu_addr,
    input wire logic [7:0]  cpu_wr_data,
    input wire logic        cpu_wr_en,
    input wire logic        cpu_rd_en,
    input wire logic [7:0]  cpu_rd_data_reg,
    input wire logic        cpu_rd_valid_reg,
    input wire logic        tx_bit_en,
    input wire logic        rx_bit_en,
    input wire logic [11:0] frame_err_count,
    input wire logic [9:0]  crc_err_count,
    input wire logic [9:0]  far_end_err_count,
    input wire logic        remote_loop_ctl,
    input wire logic        local_loop_ctl,
    input wire logic        line_alarm_gen_en,
    input wire logic        tx_byte_update,
    input wire logic        rx_byte_update
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_RD_VALID: assert property (cpu_rd_en |=> cpu_rd_valid_reg)
        else $error("read without valid");
    AST_FAS_UPPER: assert property (cpu_rd_en && cpu_addr == 8'h02 |=>
        cpu_rd_data_reg == {$past(frame_err_count[11:6]), $past(crc_err_count[9:8])})
        else $error("upper count mismatch");
    AST_FAS_LOWER: assert property (cpu_rd_en && cpu_addr == 8'h04 |=>
        cpu_rd_data_reg == {$past(frame_err_count[5:0]), $past(far_end_err_count[9:8])})
        else $error("lower count mismatch");
    AST_SEL_READBACK: assert property ((cpu_wr_en && cpu_addr == 8'hA8) ##1 !cpu_wr_en
        ##1 (cpu_rd_en && cpu_addr == 8'hA8 && !cpu_wr_en)
        |=> cpu_rd_data_reg == $past(cpu_wr_data, 3))
        else $error("select readback mismatch");
    AST_CTRL_COPY: assert property ((cpu_wr_en && cpu_addr == 8'hA8) ##1 !cpu_wr_en |=>
        {remote_loop_ctl, local_loop_ctl, line_alarm_gen_en} == $past(cpu_wr_data[7:5], 2))
        else $error("control bits not copied");
    AST_TX_UPD_PULSE: assert property (tx_byte_update |=> !tx_byte_update)
        else $error("transmit update too long");
    AST_TX_UPD_CAUSE: assert property (tx_byte_update |-> $past(tx_bit_en, 2))
        else $error("transmit update without bit");
    AST_RX_UPD_CAUSE: assert property (rx_byte_update |-> $past(rx_bit_en, 2))
        else $error("receive update without bit");
    AST_RX_UPD_PULSE: assert property (rx_byte_update |=> !rx_byte_update)
        else $error("receive update too long");
    AST_RD_VALID_CAUSE: assert property (cpu_rd_valid_reg |-> $past(cpu_rd_en))
        else $error("valid without read");
endmodule // dcm_mon_props
`default_nettype wire

// file: tb/tb.sv
// Register-level testbench for the timeslot monitor
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb;
    logic        sys_clk, rst, cpu_wr_en, cpu_rd_en, cpu_rd_valid_reg;
    logic [7:0]  cpu_addr, cpu_wr_data, cpu_rd_data_reg;
    logic        tx_bit_en, tx_frame_sync, tx_data_bit, rx_bit_en, rx_frame_sync, rx_data_bit;
    logic [11:0] frame_err_count;
    logic [9:0]  crc_err_count, far_end_err_count;
    logic        remote_loop_ctl, local_loop_ctl, line_alarm_gen_en, line_if_reset;
    logic        tx_byte_update, rx_byte_update;
    int          errors, samples_checked;
    int          ts[3] = '{5, 0, 31};
    int          rs[3] = '{14, 31, 0};
    logic [2:0]  ctl[3] = '{3'b111, 3'b010, 3'b101};

    dcm_channel_monitor dut (.sys_clk, .rst, .cpu_addr, .cpu_wr_data, .cpu_wr_en, .cpu_rd_en,
        .cpu_rd_data_reg, .cpu_rd_valid_reg, .tx_bit_en, .tx_frame_sync, .tx_data_bit,
        .rx_bit_en, .rx_frame_sync, .rx_data_bit, .frame_err_count, .crc_err_count,
        .far_end_err_count, .remote_loop_ctl, .local_loop_ctl, .line_alarm_gen_en,
        .line_if_reset, .tx_byte_update, .rx_byte_update);

    function automatic logic [7:0] txb(input int s);
        return 8'h3C ^ 8'(s * 7);
    endfunction
    function automatic logic [7:0] rxb(input int s);
        return 8'hC3 ^ 8'(s * 11);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_wr_data <= d;
        cpu_wr_en <= 1'b1;
        @(posedge sys_clk);
        cpu_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_rd_en <= 1'b1;
        @(posedge sys_clk);
        cpu_rd_en <= 1'b0;
        #1;
        `CHK(cpu_rd_valid_reg, 1'b1)
        `CHK(cpu_rd_data_reg, e)
    endtask

    // Both streams run a full frame side by side, first bit of each slot first
    task automatic frame();
        logic [7:0] t;
        logic [7:0] r;
        int         nt;
        int         nr;
        nt = 0;
        nr = 0;
        for (int p = 0; p < 256; p++)
        begin
            t = txb(p / 8);
            r = rxb(p / 8);
            @(posedge sys_clk);
            nt += (tx_byte_update === 1'b1);
            nr += (rx_byte_update === 1'b1);
            tx_bit_en <= 1'b1;
            rx_bit_en <= 1'b1;
            tx_frame_sync <= (p == 0);
            rx_frame_sync <= (p == 0);
            tx_data_bit <= t[7 - p % 8];
            rx_data_bit <= r[7 - p % 8];
        end
        @(posedge sys_clk);
        nt += (tx_byte_update === 1'b1);
        nr += (rx_byte_update === 1'b1);
        tx_bit_en <= 1'b0;
        rx_bit_en <= 1'b0;
        repeat (3)
        begin
            @(posedge sys_clk);
            nt += (tx_byte_update === 1'b1);
            nr += (rx_byte_update === 1'b1);
        end
        `CHK(nt, 1)
        `CHK(nr, 1)
    endtask

    task automatic results();
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        #50000;
        errors++;
        results();
    end

    initial
    begin
        {rst, cpu_wr_en, cpu_rd_en, cpu_addr, cpu_wr_data} = {1'b1, 18'h0};
        {tx_bit_en, tx_frame_sync, tx_data_bit, rx_bit_en, rx_frame_sync, rx_data_bit} = 6'h00;
        {frame_err_count, crc_err_count, far_end_err_count} = 32'h0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'hA8, 8'h00);
        rd(8'hAB, 8'h00);
        wr(8'hA9, 8'h5A);
        rd(8'hA9, 8'h00);
        rd(8'h10, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            frame_err_count <= k ? 12'hFFF : 12'hA5C;
            crc_err_count <= k ? 10'h0FF : 10'h2C1;
            far_end_err_count <= k ? 10'h300 : 10'h1B7;
            @(posedge sys_clk);
            rd(8'h02, {frame_err_count[11:6], crc_err_count[9:8]});
            rd(8'h04, {frame_err_count[5:0], far_end_err_count[9:8]});
        end
        for (int i = 0; i < 3; i++)
        begin
            wr(8'hA8, {ctl[i], 5'(ts[i])});
            rd(8'hA8, {ctl[i], 5'(ts[i])});
            `CHK({remote_loop_ctl, local_loop_ctl, line_alarm_gen_en}, ctl[i])
            wr(8'hAA, {ctl[i][2], 2'b11, 5'(rs[i])});
            rd(8'hAA, {ctl[i][2], 2'b00, 5'(rs[i])});
            `CHK(line_if_reset, ctl[i][2])
            frame();
            rd(8'hA9, txb(ts[i]));
            rd(8'hAB, rxb(rs[i]));
        end
        results();
    end
endmodule // tb

bind dcm_channel_monitor dcm_mon_props u_props (.sys_clk, .rst, .cpu_addr, .cpu_wr_data,
    .cpu_wr_en, .cpu_rd_en, .cpu_rd_data_reg, .cpu_rd_valid_reg, .tx_bit_en, .rx_bit_en,
    .frame_err_count, .crc_err_count, .far_end_err_count, .remote_loop_ctl,
    .local_loop_ctl, .line_alarm_gen_en, .tx_byte_update, .rx_byte_update);
`default_nettype wire
